// *** hdl/jspsr_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module jspsr_regs (
  input  wire logic                i_mclk,
  input  wire logic                i_srst,
  input  wire logic                i_config_mode,
  input  wire logic                i_periphery_active,
  input  wire logic                i_tm_a_slave_ok,
  input  wire logic                i_tm_b_slave_ok,
  input  wire jspsr_pkg::jspsr_dr_t i_dr_sel,
  input  wire logic                i_capture_dr,
  input  wire logic                i_shift_dr,
  input  wire logic                i_update_dr,
  input  wire logic                i_tdi,
  output logic                     o_tdo,
  output logic [4:0]               o_port_select_code,
  output logic [19:0]              o_port_onehot,
  output logic [4:0]               o_selected_port_indicator_n
);

  // ****************************************
  // state
  // ****************************************
  logic [4:0]  sel_q,   sel_d;
  logic [31:0] scr1_q,  scr1_d;
  logic [31:0] scr2_q,  scr2_d;
  logic [31:0] shreg_q, shreg_d;
  logic        tdo_q,   tdo_d;
  logic [19:0] hot_q,   hot_d;
  logic [4:0]  ind_q,   ind_d;
  logic        dec_valid;
  logic [19:0] dec_hot;
  logic [4:0]  dec_ind;
  logic        scan_ok;

  jspsr_port_decode u_dec (
    .i_code        (sel_q),
    .i_slave_a_ok  (i_tm_a_slave_ok),
    .i_slave_b_ok  (i_tm_b_slave_ok),
    .o_valid       (dec_valid),
    .o_onehot      (dec_hot),
    .o_indicator_n (dec_ind)
  );

  // ****************************************
  // scan path and register writes
  // ****************************************
  // the select field is only five stages long so its scan length matches the field
  always_comb begin
    scan_ok = ~i_periphery_active;
    sel_d   = sel_q;
    scr1_d  = scr1_q;
    scr2_d  = scr2_q;
    shreg_d = shreg_q;
    if (scan_ok && i_capture_dr) begin
      case (i_dr_sel)
        jspsr_pkg::DR_SEL:  shreg_d = {27'h0000000, sel_q};
        jspsr_pkg::DR_SCR1: shreg_d = scr1_q;
        jspsr_pkg::DR_SCR2: shreg_d = scr2_q;
        default:            shreg_d = 32'h00000000;
      endcase
    end else if (scan_ok && i_shift_dr) begin
      case (i_dr_sel)
        jspsr_pkg::DR_SEL: shreg_d = {27'h0000000, i_tdi, shreg_q[4:1]};
        default:           shreg_d = {i_tdi, shreg_q[31:1]};
      endcase
    end else if (scan_ok && i_update_dr) begin
      case (i_dr_sel)
        jspsr_pkg::DR_SEL: begin
          if (i_config_mode) begin
            sel_d = shreg_q[4:0];
          end
        end
        jspsr_pkg::DR_SCR1: scr1_d = shreg_q;
        jspsr_pkg::DR_SCR2: scr2_d = shreg_q;
        default:            sel_d  = sel_q;
      endcase
    end
    tdo_d = shreg_d[0];
    // ports drop while configuring or while periphery scan owns the pins
    hot_d = (i_config_mode || i_periphery_active) ? 20'h00000 : dec_hot;
    ind_d = i_periphery_active ? jspsr_pkg::IND_NONE : dec_ind;
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      sel_q   <= jspsr_pkg::SEL_RST;
      scr1_q  <= jspsr_pkg::SCR1_RST;
      shreg_q <= 32'h00000000;
      tdo_q   <= 1'b0;
      hot_q   <= 20'h00000;
      ind_q   <= jspsr_pkg::IND_NONE;
    end else begin
      sel_q   <= sel_d;
      scr1_q  <= scr1_d;
      shreg_q <= shreg_d;
      tdo_q   <= tdo_d;
      hot_q   <= hot_d;
      ind_q   <= ind_d;
    end
  end

  // no reset here: content stays undefined until the first write
  always_ff @(posedge i_mclk) begin
    scr2_q <= scr2_d;
  end

  assign o_tdo                       = tdo_q;
  assign o_port_select_code          = sel_q;
  assign o_port_onehot               = hot_q;
  assign o_selected_port_indicator_n = ind_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  sel_reset_a: assert property (@(posedge i_mclk) disable iff (1'b0)
    i_srst |=> (sel_q == 5'h00)) else $error("select field not zero after reset");
  scr1_reset_a: assert property (@(posedge i_mclk) disable iff (1'b0)
    i_srst |=> (scr1_q == 32'h00000000)) else $error("scratch one not zero after reset");
  // a reset in mid-run also moves the field, so the edge after reset is let through
  sel_cfg_only_a: assert property (
    $changed(sel_q) |-> $past(i_srst) || $past(i_update_dr && i_config_mode && !i_periphery_active
                              && !i_capture_dr && !i_shift_dr)) else $error("select changed outside configuration");
  cfg_deselect_a: assert property (
    i_config_mode |=> (o_port_onehot == 20'h00000)) else $error("port selected in configuration mode");
  periph_prio_a: assert property (
    i_periphery_active |=> (o_port_onehot == 20'h00000) && (o_selected_port_indicator_n == 5'h1F))
    else $error("periphery did not override selection");
  ind_none_a: assert property (
    (!i_periphery_active && (sel_q == 5'h00 || sel_q > 5'h14)) |=> (o_selected_port_indicator_n == 5'h1F))
    else $error("indicator not idle for no-port code");
  ind_code_a: assert property (
    (!i_periphery_active && !$changed(sel_q) && sel_q >= 5'h01 && sel_q <= 5'h12)
      |=> (o_selected_port_indicator_n == ~$past(sel_q))) else $error("indicator not complement of code");
  slave_gate_a: assert property (
    (sel_q == 5'h13 && !i_tm_a_slave_ok && !i_periphery_active)
      |=> (o_selected_port_indicator_n == 5'h1F) && (o_port_onehot[18] == 1'b0))
    else $error("port 19 used without slave permission");
  scr_readback_a: assert property (
    (i_update_dr && !i_capture_dr && !i_shift_dr && !i_periphery_active && i_dr_sel == jspsr_pkg::DR_SCR1)
      ##1 (!i_update_dr)[*1] |=> (scr1_q == $past(shreg_q, 2))) else $error("scratch one lost written value");


  // ****************************************
  // reset values seen on the pins
  // ****************************************
  out_reset_a: assert property (@(posedge i_mclk) disable iff (1'b0)
    i_srst |=> (o_tdo == 1'b0) && (o_port_onehot == 20'h00000) && (o_selected_port_indicator_n == 5'h1F))
    else $error("outputs not idle after reset");

  // ****************************************
  // scan path behaviour
  // ****************************************
  // o_tdo must always be the bit that the next shift pushes out
  tdo_shift_a: assert property (
    (i_shift_dr && !i_capture_dr && !i_periphery_active) |=> (o_tdo == $past(shreg_q[1])))
    else $error("serial output not next shift bit");

  tdo_capture_a: assert property (
    (i_capture_dr && !i_periphery_active && i_dr_sel == jspsr_pkg::DR_SCR1) |=> (o_tdo == $past(scr1_q[0])))
    else $error("capture did not load scratch one");

  scr1_write_a: assert property (
    (i_update_dr && !i_capture_dr && !i_shift_dr && !i_periphery_active && i_dr_sel == jspsr_pkg::DR_SCR1)
      |=> (scr1_q == $past(shreg_q))) else $error("scratch one write lost");

  // scratch two has no reset, so only a written value is ever compared
  scr2_write_a: assert property (
    (i_update_dr && !i_capture_dr && !i_shift_dr && !i_periphery_active && i_dr_sel == jspsr_pkg::DR_SCR2)
      |=> (scr2_q == $past(shreg_q))) else $error("scratch two write lost");

  cfg_select_a: assert property (
    (i_update_dr && i_config_mode && !i_capture_dr && !i_shift_dr && !i_periphery_active
      && i_dr_sel == jspsr_pkg::DR_SEL) |=> (sel_q == $past(shreg_q[4:0])))
    else $error("select update in configuration lost");

  // ****************************************
  // periphery scan priority
  // ****************************************
  // the periphery owner may not see its scans disturb any switch register
  periph_hold_a: assert property (
    i_periphery_active |=> $stable(sel_q) && $stable(scr1_q))
    else $error("register changed while periphery active");

  // ****************************************
  // port decoding
  // ****************************************
  onehot_single_a: assert property (
    $onehot0(o_port_onehot)) else $error("more than one port selected");

  port_map_a: assert property (
    (!i_config_mode && !i_periphery_active && !$changed(sel_q) && sel_q >= 5'h01 && sel_q <= 5'h12)
      |=> (o_port_onehot[$past(sel_q) - 5'h01] == 1'b1)) else $error("wrong port for code");

  slave_gate_b_a: assert property (
    (sel_q == 5'h14 && !i_tm_b_slave_ok && !i_periphery_active)
      |=> (o_selected_port_indicator_n == 5'h1F) && (o_port_onehot[19] == 1'b0))
    else $error("port 20 used without slave permission");

  slave_open_a: assert property (
    (sel_q == 5'h13 && i_tm_a_slave_ok && !i_periphery_active && !i_config_mode && !$changed(sel_q))
      |=> (o_port_onehot[18] == 1'b1)) else $error("port 19 not given with permission");

  // configuration mode drops every port, even one that was selected before
  cfg_all_off_a: assert property (
    (i_config_mode && !i_periphery_active) |=> !(|o_port_onehot))
    else $error("port left on in configuration mode");

endmodule : jspsr_regs
`default_nettype wire

// *** hdl/jspsr_pkg.sv ***
package jspsr_pkg;

  // ****************************************
  // widths and reset values
  // ****************************************
  localparam int unsigned SEL_W     = 5;
  localparam int unsigned SCR_W     = 32;
  localparam int unsigned PORT_CNT  = 20;
  localparam logic [4:0]  SEL_RST   = 5'h00;
  localparam logic [31:0] SCR1_RST  = 32'h00000000;
  localparam logic [4:0]  IND_NONE  = 5'h1F;
  localparam logic [4:0]  PORT_LAST = 5'h12;
  localparam logic [4:0]  PORT_TMA  = 5'h13;
  localparam logic [4:0]  PORT_TMB  = 5'h14;

  // ****************************************
  // data register chosen by the switch tap
  // ****************************************
  typedef enum logic [1:0] {
    DR_SEL  = 2'b00,
    DR_SCR1 = 2'b01,
    DR_SCR2 = 2'b10,
    DR_NONE = 2'b11
  } jspsr_dr_t;

endpackage : jspsr_pkg

// *** hdl/jspsr_port_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
module jspsr_port_decode (
  input  wire logic [4:0]  i_code,
  input  wire logic        i_slave_a_ok,
  input  wire logic        i_slave_b_ok,
  output logic             o_valid,
  output logic [19:0]      o_onehot,
  output logic [4:0]       o_indicator_n
);

  // ****************************************
  // code to port
  // ****************************************
  logic [4:0] idx;

  always_comb begin
    idx     = i_code - 5'h01;
    o_valid = 1'b0;
    if ((i_code != 5'h00) && (i_code <= jspsr_pkg::PORT_LAST)) begin
      o_valid = 1'b1;
    end else if (i_code == jspsr_pkg::PORT_TMA) begin
      o_valid = i_slave_a_ok;
    end else if (i_code == jspsr_pkg::PORT_TMB) begin
      o_valid = i_slave_b_ok;
    end
    o_onehot      = o_valid ? (20'h00001 << idx) : 20'h00000;
    o_indicator_n = o_valid ? ~i_code : jspsr_pkg::IND_NONE;
  end

endmodule : jspsr_port_decode
`default_nettype wire

// *** verif/jspsr_scan_master.sv ***
`timescale 1ns/1ps
`default_nettype none
module jspsr_scan_master (
  input  wire logic            i_mclk,
  input  wire logic            i_tdo,
  output jspsr_pkg::jspsr_dr_t o_dr_sel,
  output logic                 o_capture_dr,
  output logic                 o_shift_dr,
  output logic                 o_update_dr,
  output logic                 o_tdi
);
  // one master only: the other request inputs are taken as tied off
  initial begin
    o_dr_sel = jspsr_pkg::DR_NONE;
    o_capture_dr = 1'h0;
    o_shift_dr = 1'h0;
    o_update_dr = 1'h0;
    o_tdi = 1'h0;
  end
  // ****************************************
  // capture, shifts lsb first, update
  // ****************************************
  task automatic scan(input jspsr_pkg::jspsr_dr_t sel, input int len, input logic [31:0] din,
                      output logic [31:0] dout);
    dout = 32'h00000000;
    @(negedge i_mclk);
    o_dr_sel = sel;
    o_capture_dr = 1'h1;
    for (int i = 0; i < len; i++) begin
      @(negedge i_mclk);
      o_capture_dr = 1'h0;
      dout[i] = i_tdo;
      o_shift_dr = 1'h1;
      o_tdi = din[i];
    end
    @(negedge i_mclk);
    o_shift_dr = 1'h0;
    o_update_dr = 1'h1;
    @(negedge i_mclk);
    o_update_dr = 1'h0;
    // idle data line flips so a stale bit is never mistaken for data
    o_tdi = ~o_tdi;
  endtask : scan
endmodule : jspsr_scan_master
`default_nettype wire

// *** verif/test_jspsr_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_jspsr_regs;
  logic                 i_mclk = 1'h0;
  logic                 i_srst = 1'h1;
  logic                 cfg = 1'h0;
  logic                 peri = 1'h0;
  logic                 ok_a = 1'h0;
  logic                 ok_b = 1'h0;
  jspsr_pkg::jspsr_dr_t sel;
  logic                 cap, sh, upd, tdi, tdo;
  logic [4:0]           code, ind_n;
  logic [19:0]          hot;
  logic [31:0]          rd;
  int                   n_errors = 0;
  int                   tests_run = 0;
  // code, slave a/b, indicators, onehot
  logic [31:0] rows [9] = '{{5'h00,2'h0,5'h1F,20'h0}, {5'h01,2'h0,5'h1E,20'h1}, {5'h13,2'h2,5'h0C,20'h40000},
    {5'h13,2'h1,5'h1F,20'h0}, {5'h14,2'h1,5'h0B,20'h80000}, {5'h14,2'h2,5'h1F,20'h0},
    {5'h15,2'h3,5'h1F,20'h0}, {5'h1F,2'h3,5'h1F,20'h0}, {5'h12,2'h0,5'h0D,20'h20000}};
  always #5 i_mclk = ~i_mclk;
  jspsr_scan_master m_u (.i_mclk(i_mclk), .i_tdo(tdo), .o_dr_sel(sel), .o_capture_dr(cap),
    .o_shift_dr(sh), .o_update_dr(upd), .o_tdi(tdi));
  jspsr_regs dut_u (.i_mclk(i_mclk), .i_srst(i_srst), .i_config_mode(cfg), .i_periphery_active(peri),
    .i_tm_a_slave_ok(ok_a), .i_tm_b_slave_ok(ok_b), .i_dr_sel(sel), .i_capture_dr(cap), .i_shift_dr(sh),
    .i_update_dr(upd), .i_tdi(tdi), .o_tdo(tdo), .o_port_select_code(code), .o_port_onehot(hot),
    .o_selected_port_indicator_n(ind_n));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  task automatic scr(input jspsr_pkg::jspsr_dr_t s, input logic [31:0] d);
    m_u.scan(s, 32, d, rd);
  endtask : scr
  initial begin
    repeat (16) @(negedge i_mclk);
    i_srst = 1'h0;
    chk({tdo, 1'h0, hot, ind_n, code}, 32'h000003E0);
    scr(jspsr_pkg::DR_SCR1, 32'hA5A5F00F);
    chk(rd, 32'h00000000);
    scr(jspsr_pkg::DR_SCR1, 32'h0F0F1234);
    chk(rd, 32'hA5A5F00F);
    scr(jspsr_pkg::DR_SCR2, 32'h3C3C5AA5);
    scr(jspsr_pkg::DR_SCR2, 32'h3C3C5AA5);
    chk(rd, 32'h3C3C5AA5);
    foreach (rows[i]) begin
      {ok_a, ok_b} = rows[i][26:25];
      cfg = 1'h1;
      m_u.scan(jspsr_pkg::DR_SEL, 5, rows[i] >> 27, rd);
      repeat (2) @(negedge i_mclk);
      chk({hot, ind_n, code}, {20'h0, rows[i][24:20], rows[i][31:27]});
      cfg = 1'h0;
      repeat (2) @(negedge i_mclk);
      chk({hot, ind_n, code}, {rows[i][19:0], rows[i][24:20], rows[i][31:27]});
    end
    // update outside configuration mode must leave the field alone
    m_u.scan(jspsr_pkg::DR_SEL, 5, 32'h00000005, rd);
    chk(code, 32'h00000012);
    peri = 1'h1;
    scr(jspsr_pkg::DR_SCR1, 32'h00000000);
    chk({hot, ind_n}, {20'h0, 5'h1F});
    peri = 1'h0;
    scr(jspsr_pkg::DR_SCR1, 32'h0F0F1234);
    chk(rd, 32'h0F0F1234);
    i_srst = 1'h1;
    @(negedge i_mclk);
    i_srst = 1'h0;
    scr(jspsr_pkg::DR_SCR1, 32'h00000000);
    chk({rd[26:0], code}, 32'h00000000);
    end_sim();
  end
endmodule : test_jspsr_regs
`default_nettype wire
